// >>> core/led_mode_pkg.sv
`default_nettype none
package led_mode_pkg;

  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned PULSE_US       = 50;
  localparam int unsigned PULSE_CYC      = PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RETRY_MS       = 10;
  localparam int unsigned RETRY_CYC      = RETRY_MS * (CLK_HZ / 1_000);
  localparam int unsigned INIT_STEP_CYC  = 1_000_000;
  localparam int unsigned WD_STEP_CYC    = 100_000;
  localparam int unsigned WD_OPTIONS     = 13;
  localparam int unsigned BAUD_MIN_HZ    = 50_000;
  localparam int unsigned BAUD_MAX_HZ    = 1_000_000;
  localparam int unsigned BIT_MAX_CYC    = CLK_HZ / BAUD_MIN_HZ;
  localparam int unsigned BIT_MIN_CYC    = CLK_HZ / BAUD_MAX_HZ;

  localparam logic [7:0]  SYNC_BYTE      = 8'h55;
  localparam logic [7:0]  UNLOCK_KEY0    = 8'hA5;
  localparam logic [7:0]  UNLOCK_KEY1    = 8'h5A;

  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_CONF      = 12'h004;
  localparam logic [11:0] ADDR_STATUS    = 12'h008;
  localparam logic [11:0] ADDR_GATE      = 12'h00C;
  localparam logic [11:0] ADDR_LINK      = 12'h010;

  localparam int unsigned CTRL_FORCE_ERR = 0;
  localparam int unsigned CTRL_FORCE_FS  = 1;
  localparam int unsigned CTRL_CLEAR_POWER_ON_BIT   = 2;
  localparam int unsigned CTRL_LEAVE_FS  = 3;
  localparam int unsigned CTRL_CLEAR_ERROR_COMMAND   = 4;
  localparam int unsigned CTRL_PROG_SEL  = 5;
  localparam int unsigned CTRL_CLR_FSF   = 6;

  localparam logic [31:0] CONF_RESET     = 32'h0000_0F00;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  typedef enum logic [2:0] {
    ST_POR    = 3'b000,
    ST_INIT   = 3'b001,
    ST_NORMAL = 3'b010,
    ST_FSAFE  = 3'b011,
    ST_PROG   = 3'b100
  } op_state_t;

  // configuration register layout
  typedef struct packed {
    logic [15:0] rsvd;
    logic [3:0]  stored_address_bits;
    logic [3:0]  init_delay_setting;
    logic [3:0]  watchdog_period_setting;
    logic [1:0]  rsvd2;
    logic        ternary_address_select;
    logic        all_fail_select;
  } conf_t;

  // fault inputs from the analog monitors
  typedef struct packed {
    logic        vs_uv;
    logic        ref_fault;
    logic        over_temp;
    logic        noncrit;
    logic [11:0] out_fail;
  } fault_in_t;

endpackage : led_mode_pkg
`default_nettype wire

// >>> core/led_mode_ctrl.sv
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`default_nettype none
// Notes on behaviour
// - fail-safe, all-fail set: output failure switches off all other enabled outputs
// - fail-safe, all-fail clear: only the faulty output is switched off
// - fail-safe, all-fail set: failed output is retried every 10 ms
// - normal: non-critical fault gives 50 us low pulse, critical holds line low
// - normal: only report faults, except undervoltage, reference and overtemperature
// - normal: force-error sets summary error, gives 50 us pulse, self-clears
// - fail-safe: any output failure sinks fault line, line level monitored
// - fail-safe: external low turns all off if all-fail set, else stays on
// - power-up: power-on reset, defaults, outputs off, host link ignored
// - leave reset when both supplies good; return on any supply drop
// - init counts delay from 4-bit setting, then goes normal
// - init enables host link and loads defaults from nonvolatile store
// - clear-power-on written in init moves immediately to normal
// - normal: watchdog counts idle host time, 13 periods, overflow enters fail-safe
// - force-fail-safe in normal enters fail-safe and self-clears
// - entering fail-safe reloads defaults; host link stays alive
// - leave-fail-safe with fail-safe flag clear returns to normal
// - program state needs unlock sequence then program-select bit
// - byte: start, eight data bits lsb first, stop, no parity
// - frame opens with sync byte; bit rate measured, 50 kHz to 1 MHz
// - binary addressing: stored bit on top, three pins below, 16 addresses
// - ternary addressing: three-level pins give 27 addresses
// - fail-safe fault line releases when fault clears; flags held until clear
module led_mode_ctrl
  import led_mode_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        vbat_good,
  input  wire logic        vldo_good,
  input  wire conf_t       nv_conf,
  input  wire fault_in_t   faults,
  input  wire logic [11:0] out_enable,
  input  wire logic [1:0]  address_pin_2,
  input  wire logic [1:0]  address_pin_1,
  input  wire logic [1:0]  address_pin_0,
  input  wire logic        rx,
  input  wire logic        fault_bus_n_in,
  output logic             fault_bus_n_out,
  output logic             fault_bus_n_oe,
  output logic [11:0]      out_on,
  output logic [4:0]       slave_address,
  output logic [7:0]       rx_byte,
  output logic             rx_byte_valid,
  output op_state_t        op_state,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  op_state_t   state_r;
  conf_t       conf_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        aw_have_r;
  logic        w_have_r;
  logic        wr_fire;
  logic [6:0]  ctrl_wr;
  logic        err_flag_r;
  logic        failsafe_flag_r;
  logic [11:0] out_fail_flag_r;
  logic [1:0]  gate_step_r;
  logic [23:0] init_cnt_r;
  logic [27:0] wd_cnt_r;
  logic [27:0] wd_limit;
  logic [15:0] pulse_cnt_r;
  logic [19:0] retry_cnt_r;
  logic        retry_on_r;
  logic        fault_low_r;
  logic        supplies_ok;
  logic        critical;
  logic        host_activity;
  logic        link_on;

  assign supplies_ok = vbat_good & vldo_good;
  assign critical    = faults.vs_uv | faults.ref_fault | faults.over_temp;
  assign link_on     = (state_r != ST_POR);
  assign op_state    = state_r;

  // ---------------- register bus
  assign s_axi_awready = ~aw_have_r;
  assign s_axi_wready  = ~w_have_r;
  assign wr_fire       = aw_have_r & w_have_r & ~s_axi_bvalid;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // host writes are refused while the link is off, answered with slverr
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (link_on && aw_addr_r <= ADDR_LINK) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign ctrl_wr = (wr_fire && link_on && aw_addr_r == ADDR_CTRL && w_strb_r[0])
                   ? w_data_r[6:0] : 7'h00;
  assign host_activity = wr_fire | (s_axi_arvalid & s_axi_arready) | rx_byte_valid;

  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CONF:   s_axi_rdata <= conf_r;
        ADDR_STATUS: s_axi_rdata <= {12'h000, out_fail_flag_r, 1'b0, fault_bus_n_in,
                                     failsafe_flag_r, err_flag_r, 1'b0, state_r};
        ADDR_GATE:   s_axi_rdata <= {30'h0, gate_step_r};
        ADDR_LINK:   s_axi_rdata <= {19'h0, slave_address, rx_byte};
        ADDR_CTRL:   s_axi_rdata <= 32'h0000_0000;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // configuration: defaults from nonvolatile image on init and fail-safe entry
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      conf_r <= CONF_RESET;
    end else if (state_r == ST_POR && supplies_ok) begin
      conf_r <= nv_conf;
    end else if (state_r == ST_NORMAL && (wd_cnt_r >= wd_limit || ctrl_wr[CTRL_FORCE_FS])) begin
      conf_r <= nv_conf;
    end else if (wr_fire && link_on && aw_addr_r == ADDR_CONF && w_strb_r[1:0] == 2'b11) begin
      conf_r[15:0] <= w_data_r[15:0];
    end
  end

  // unlock sequence: two keys in order, any other write to the gate register restarts it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_step_r <= 2'd0;
    end else if (state_r == ST_POR) begin
      gate_step_r <= 2'd0;
    end else if (wr_fire && link_on && aw_addr_r == ADDR_GATE) begin
      if (gate_step_r == 2'd0 && w_data_r[7:0] == UNLOCK_KEY0) begin
        gate_step_r <= 2'd1;
      end else if (gate_step_r == 2'd1 && w_data_r[7:0] == UNLOCK_KEY1) begin
        gate_step_r <= 2'd2;
      end else begin
        gate_step_r <= 2'd0;
      end
    end
  end

  // watchdog period options 0..12 scale one step; codes above 12 take the longest
  always_comb begin
    if (conf_r.watchdog_period_setting >= 4'(WD_OPTIONS)) begin
      wd_limit = 28'(WD_OPTIONS * WD_STEP_CYC);
    end else begin
      wd_limit = 28'((32'(conf_r.watchdog_period_setting) + 32'd1) * WD_STEP_CYC);
    end
  end

  // ---------------- operating state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_POR;
    end else if (!supplies_ok) begin
      state_r <= ST_POR;
    end else begin
      case (state_r)
        ST_POR: state_r <= ST_INIT;
        ST_INIT: begin
          if (ctrl_wr[CTRL_CLEAR_POWER_ON_BIT] ||
              init_cnt_r >= 24'(32'(conf_r.init_delay_setting) * INIT_STEP_CYC)) begin
            state_r <= ST_NORMAL;
          end
        end
        ST_NORMAL: begin
          if (wd_cnt_r >= wd_limit || ctrl_wr[CTRL_FORCE_FS]) begin
            state_r <= ST_FSAFE;
          end else if (ctrl_wr[CTRL_PROG_SEL] && gate_step_r == 2'd2) begin
            state_r <= ST_PROG;
          end
        end
        ST_FSAFE: begin
          if (ctrl_wr[CTRL_LEAVE_FS] && !failsafe_flag_r) begin
            state_r <= ST_NORMAL;
          end else if (ctrl_wr[CTRL_PROG_SEL] && gate_step_r == 2'd2) begin
            state_r <= ST_PROG;
          end
        end
        ST_PROG: state_r <= ST_PROG;
        default: state_r <= ST_POR;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      init_cnt_r <= 24'd0;
    end else if (state_r == ST_INIT) begin
      init_cnt_r <= init_cnt_r + 24'd1;
    end else begin
      init_cnt_r <= 24'd0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_cnt_r <= 28'd0;
    end else if (state_r != ST_NORMAL || host_activity) begin
      wd_cnt_r <= 28'd0;
    end else begin
      wd_cnt_r <= wd_cnt_r + 28'd1;
    end
  end

  // ---------------- flags; a new event wins over a host clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_flag_r      <= 1'b0;
      out_fail_flag_r <= 12'h000;
      failsafe_flag_r <= 1'b0;
    end else begin
      if (ctrl_wr[CTRL_FORCE_ERR] && state_r == ST_NORMAL) begin
        err_flag_r <= 1'b1;
      end else if (critical || faults.noncrit || (|faults.out_fail)) begin
        err_flag_r <= 1'b1;
      end else if (ctrl_wr[CTRL_CLEAR_ERROR_COMMAND]) begin
        err_flag_r <= 1'b0;
      end
      for (int i = 0; i < 12; i++) begin
        if (faults.out_fail[i]) begin
          out_fail_flag_r[i] <= 1'b1;
        end else if (ctrl_wr[CTRL_CLEAR_ERROR_COMMAND]) begin
          out_fail_flag_r[i] <= 1'b0;
        end
      end
      if (state_r == ST_NORMAL && (wd_cnt_r >= wd_limit || ctrl_wr[CTRL_FORCE_FS])) begin
        failsafe_flag_r <= 1'b1;
      end else if (ctrl_wr[CTRL_CLR_FSF]) begin
        failsafe_flag_r <= 1'b0;
      end
    end
  end

  // ---------------- fault line
  logic event_pulse;
  assign event_pulse = state_r == ST_NORMAL &&
                       (faults.noncrit || (|faults.out_fail) || ctrl_wr[CTRL_FORCE_ERR]);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_cnt_r <= 16'd0;
    end else if (event_pulse && pulse_cnt_r == 16'd0) begin
      pulse_cnt_r <= 16'(PULSE_CYC);
    end else if (pulse_cnt_r != 16'd0) begin
      pulse_cnt_r <= pulse_cnt_r - 16'd1;
    end
  end

  // in fail-safe the fault line output follows live conditions, so it releases when they clear; in normal a pulse runs its full length
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_low_r <= 1'b0;
    end else begin
      case (state_r)
        ST_NORMAL: fault_low_r <= critical || pulse_cnt_r != 16'd0;
        ST_FSAFE:  fault_low_r <= critical || (|faults.out_fail);
        default:   fault_low_r <= 1'b0;
      endcase
    end
  end
  assign fault_bus_n_out = 1'b0;
  assign fault_bus_n_oe  = fault_low_r;

  // ---------------- outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      retry_cnt_r <= 20'd0;
      retry_on_r  <= 1'b0;
    end else if (retry_cnt_r == 20'(RETRY_CYC - 1)) begin
      retry_cnt_r <= 20'd0;
      retry_on_r  <= 1'b1;
    end else begin
      retry_cnt_r <= retry_cnt_r + 20'd1;
      retry_on_r  <= 1'b0;
    end
  end

  // the external level is read straight: pins are taken as synchronous
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_on <= 12'h000;
    end else begin
      case (state_r)
        ST_NORMAL: out_on <= critical ? 12'h000 : out_enable;
        ST_FSAFE: begin
          if (critical) begin
            out_on <= 12'h000;
          end else if (conf_r.all_fail_select) begin
            if (|faults.out_fail) begin
              out_on <= retry_on_r ? (out_enable & out_fail_flag_r) : 12'h000;
            end else if (!fault_bus_n_in) begin
              out_on <= 12'h000;
            end else begin
              out_on <= out_enable;
            end
          end else begin
            out_on <= out_enable & ~faults.out_fail;
          end
        end
        default: out_on <= 12'h000;
      endcase
    end
  end

  // ---------------- address: latched as init starts
  logic [4:0] tern_addr;
  logic       any_mid;
  assign any_mid = address_pin_2 == 2'd2 || address_pin_1 == 2'd2 || address_pin_0 == 2'd2;
  always_comb begin
    tern_addr = {2'b00, address_pin_2[0], address_pin_1[0], address_pin_0[0]};
    if (any_mid) begin
      case ({address_pin_2 == 2'd2, address_pin_1 == 2'd2, address_pin_0 == 2'd2})
        3'b001:  tern_addr = 5'd8 + {3'b000, address_pin_2[0], address_pin_1[0]};
        3'b010:  tern_addr = 5'd12 + {3'b000, address_pin_2[0], address_pin_0[0]};
        3'b100:  tern_addr = 5'd16 + {3'b000, address_pin_1[0], address_pin_0[0]};
        3'b011:  tern_addr = 5'd20 + {4'b0000, address_pin_2[0]};
        3'b101:  tern_addr = 5'd22 + {4'b0000, address_pin_1[0]};
        3'b110:  tern_addr = 5'd24 + {4'b0000, address_pin_0[0]};
        default: tern_addr = 5'd26;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slave_address <= 5'd0;
    end else if (state_r == ST_POR && supplies_ok) begin
      slave_address <= nv_conf.ternary_address_select ? tern_addr :
                       {1'b0, nv_conf.stored_address_bits[3], address_pin_2[0],
                        address_pin_1[0], address_pin_0[0]};
    end
  end

  // ---------------- serial byte receiver with sync-byte rate measurement
  logic [1:0]  rx_ph_r;
  logic [11:0] bit_len_r;
  logic [14:0] cnt_r;
  logic [3:0]  bit_idx_r;
  logic [3:0]  edge_cnt_r;
  logic [7:0]  shift_r;
  logic        rx_prev_r;
  logic        synced_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_ph_r       <= 2'd0;
      bit_len_r     <= 12'd0;
      cnt_r         <= 15'd0;
      bit_idx_r     <= 4'd0;
      edge_cnt_r    <= 4'd0;
      shift_r       <= 8'h00;
      rx_prev_r     <= 1'b1;
      synced_r      <= 1'b0;
      rx_byte       <= 8'h00;
      rx_byte_valid <= 1'b0;
    end else begin
      rx_prev_r     <= rx;
      rx_byte_valid <= 1'b0;
      if (!link_on) begin
        rx_ph_r <= 2'd0;
        synced_r <= 1'b0;
        bit_idx_r <= 4'd0;
      end else case (rx_ph_r)
        2'd0: if (rx_prev_r && !rx) begin
          cnt_r <= 15'd0;
          edge_cnt_r <= 4'd0;
          rx_ph_r <= synced_r ? 2'd2 : 2'd1;
        end
        // sync 0x55: start falling edge to the stop-bit rising edge spans 9 bits
        2'd1: begin
          cnt_r <= cnt_r + 15'd1;
          if (rx != rx_prev_r) edge_cnt_r <= edge_cnt_r + 4'd1;
          // the slowest sync byte spans 18000 cycles, hence the 15-bit counter
          if (cnt_r == 15'(BIT_MAX_CYC * 9)) rx_ph_r <= 2'd0;
          else if (edge_cnt_r == 4'd8 && rx && !rx_prev_r) begin
            bit_len_r <= 12'(32'(cnt_r) / 9);
            synced_r <= (32'(cnt_r) / 9) >= BIT_MIN_CYC;
            rx_ph_r <= 2'd3;
          end
        end
        2'd2: begin
          cnt_r <= cnt_r + 15'd1;
          if (cnt_r == {3'b000, (bit_idx_r == 4'd0 ? bit_len_r >> 1 : bit_len_r)}) begin
            cnt_r <= 15'd0;
            bit_idx_r <= bit_idx_r + 4'd1;
            if (bit_idx_r == 4'd0 && rx) begin
              rx_ph_r <= 2'd0;                                                // false start
              bit_idx_r <= 4'd0;
            end else if (bit_idx_r >= 4'd1 && bit_idx_r <= 4'd8)
              shift_r <= {rx, shift_r[7:1]};
            else if (bit_idx_r == 4'd9) begin
              rx_ph_r <= 2'd3;
              bit_idx_r <= 4'd0;
              rx_byte_valid <= rx;
              rx_byte <= shift_r;
            end
          end
        end
        default: if (rx) begin
          rx_ph_r <= 2'd0;
          bit_idx_r <= 4'd0;
        end
      endcase
    end
  end

endmodule : led_mode_ctrl
`default_nettype wire

// >>> tb/led_mode_ctrl_monitor.sv
`default_nettype none
module led_mode_ctrl_monitor
  import led_mode_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        vbat_good,
  input wire logic        vldo_good,
  input wire fault_in_t   faults,
  input wire logic        fault_bus_n_oe,
  input wire logic [11:0] out_on,
  input wire logic [4:0]  slave_address,
  input wire logic        rx_byte_valid,
  input wire op_state_t   op_state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  int unsigned cnt_r;
  logic        crit_r;
  // a pulse overlapped by a critical fault has no fixed length, so it is not judged
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r  <= 0;
      crit_r <= 1'b0;
    end else begin
      cnt_r  <= fault_bus_n_oe ? cnt_r + 1 : 0;
      crit_r <= fault_bus_n_oe & (crit_r | faults.over_temp | faults.ref_fault | faults.vs_uv);
    end
  end
  property p_por_off; (op_state == ST_POR)[*2] |-> out_on == 12'h000; endproperty
  a_por_off: assert property (p_por_off) else $error("outputs on in reset state");
  property p_por_link; op_state == ST_POR |-> !rx_byte_valid; endproperty
  a_por_link: assert property (p_por_link) else $error("byte taken in reset state");
  property p_drop; !(vbat_good && vldo_good) |=> op_state == ST_POR; endproperty
  a_drop: assert property (p_drop) else $error("no return to reset state");
  property p_up; op_state == ST_POR && vbat_good && vldo_good |=> op_state == ST_INIT; endproperty
  a_up: assert property (p_up) else $error("no move to init");
  property p_crit;
    op_state == ST_NORMAL && faults.over_temp ##1 faults.over_temp |-> fault_bus_n_oe;
  endproperty
  a_crit: assert property (p_crit) else $error("critical fault not held");
  property p_pulse;
    op_state == ST_NORMAL && $fell(fault_bus_n_oe) && !crit_r |-> cnt_r == PULSE_CYC;
  endproperty
  a_pulse: assert property (p_pulse) else $error("fault pulse length wrong");
  property p_sink;
    op_state == ST_FSAFE && faults.out_fail != 0 |=> fault_bus_n_oe || op_state != ST_FSAFE;
  endproperty
  a_sink: assert property (p_sink) else $error("fault line not sunk");
  property p_addr;
    op_state != ST_POR && $past(op_state) != ST_POR |-> $stable(slave_address);
  endproperty
  a_addr: assert property (p_addr) else $error("address changed after latch");
endmodule : led_mode_ctrl_monitor
bind led_mode_ctrl led_mode_ctrl_monitor u_monitor (.clk, .arst_n, .vbat_good, .vldo_good,
  .faults, .fault_bus_n_oe, .out_on, .slave_address, .rx_byte_valid, .op_state);
`default_nettype wire

// >>> tb/led_host_link.sv
`default_nettype none
module led_host_link #(
  parameter int BIT_CYC = 200
) (
  input  wire logic clk,
  output var logic  rx
);
  timeunit 1ns;
  timeprecision 1ps;
  // line idles high between frames
  initial rx = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rx <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
  endtask : send
endmodule : led_host_link
`default_nettype wire

// >>> tb/led_mode_ctrl_tb_top.sv
`default_nettype none
module led_mode_ctrl_tb_top
  import led_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, arst_n, vbat_good, vldo_good, rx, fault_ext, fault_bus_n_in;
  logic        fault_bus_n_out, fault_bus_n_oe, rx_byte_valid;
  conf_t       nv_conf;
  fault_in_t   faults;
  logic [11:0] out_enable, out_on, s_axi_awaddr, s_axi_araddr, en;
  logic [1:0]  address_pin_2, address_pin_1, address_pin_0, s_axi_bresp, s_axi_rresp;
  logic [4:0]  slave_address;
  logic [7:0]  rx_byte, lb;
  op_state_t   op_state;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          errors, num_checks, n;
  logic [7:0]  exp_q[$];
  // open-drain line with pull-up
  assign fault_bus_n_in = !(fault_bus_n_oe | fault_ext);
  led_mode_ctrl DUT (.*);
  led_host_link #(.BIT_CYC(200)) host (.clk(clk), .rx(rx));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    logic ta, tw, b;
    logic [1:0] rsp;
    logic [31:0] rd;
    @(posedge clk);
    if (w) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    else {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    // ready is judged before the edge so the release lands just after it
    do begin
      @(negedge clk);
      ta = w ? s_axi_awready : s_axi_arready;
      tw = w & s_axi_wready;
      b = w ? s_axi_bvalid : s_axi_rvalid;
      rsp = w ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge clk);
      if (ta && w) s_axi_awvalid <= 1'b0;
      if (ta && !w) s_axi_arvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!b);
    if (w) s_axi_bready <= 1'b0;
    else s_axi_rready <= 1'b0;
    chk("resp", er, rsp);
    if (!w) chk("rdata", d, rd);
  endtask : bus
  task automatic wst(input op_state_t s);
    n = 0;
    while (op_state !== s && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk("state", s, op_state);
  endtask : wst
  task automatic pw();
    n = 0;
    repeat (20) if (fault_bus_n_oe !== 1'b1) @(negedge clk);
    while (fault_bus_n_oe === 1'b1 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    chk("pulse", PULSE_CYC, n);
  endtask : pw
  always @(negedge clk)
    if (rx_byte_valid === 1'b1) chk("rx_byte", exp_q.pop_front(), rx_byte);
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    results();
  end
  initial begin
    void'($urandom(32'h95CF));
    {arst_n, vbat_good, vldo_good, fault_ext, faults} = '0;
    nv_conf = 32'h0000_80F1;
    en = 12'($urandom) | 12'h00C;
    out_enable = en;
    {address_pin_2, address_pin_1, address_pin_0} = 6'b01_00_01;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    wst(ST_POR);
    bus(1'b1, ADDR_CTRL, 32'h4, RESP_SLVERR);
    {vbat_good, vldo_good} <= 2'b11;
    wst(ST_NORMAL);
    chk("address", 5'd13, slave_address);
    host.send(SYNC_BYTE);
    repeat (3) begin
      lb = 8'($urandom);
      exp_q.push_back(lb);
      host.send(lb);
    end
    chk("rx_left", 0, exp_q.size());
    bus(1'b0, ADDR_LINK, {19'h0, 5'd13, lb}, RESP_OKAY);
    bus(1'b1, ADDR_CTRL, 32'h1, RESP_OKAY);
    pw();
    bus(1'b0, ADDR_STATUS, 32'h0000_0052, RESP_OKAY);
    @(posedge clk) faults.noncrit <= 1'b1;
    @(posedge clk) faults.noncrit <= 1'b0;
    pw();
    @(posedge clk) faults.over_temp <= 1'b1;
    repeat (20) @(negedge clk);
    chk("crit", 1, fault_bus_n_oe);
    @(posedge clk) faults.over_temp <= 1'b0;
    bus(1'b1, ADDR_CTRL, 32'h10, RESP_OKAY);
    bus(1'b1, ADDR_CTRL, 32'h2, RESP_OKAY);
    wst(ST_FSAFE);
    @(posedge clk) faults.out_fail <= 12'h008;
    repeat (4) @(negedge clk);
    chk("out_on", 12'h000, out_on & 12'hFF7);
    chk("sink", 1, fault_bus_n_oe);
    @(posedge clk) faults.out_fail <= 12'h000;
    repeat (4) @(negedge clk);
    chk("sink", 0, fault_bus_n_oe);
    @(posedge clk) fault_ext <= 1'b1;
    repeat (4) @(negedge clk);
    chk("out_on", 12'h000, out_on);
    @(posedge clk) fault_ext <= 1'b0;
    bus(1'b1, ADDR_CONF, 32'h80F0, RESP_OKAY);
    faults.out_fail <= 12'h004;
    repeat (4) @(negedge clk);
    chk("out_on", en & 12'hFFB, out_on);
    @(posedge clk) {faults.out_fail, fault_ext} <= 13'h001;
    repeat (4) @(negedge clk);
    chk("out_on", en, out_on);
    @(posedge clk) fault_ext <= 1'b0;
    bus(1'b0, 12'h0FC, 32'h0, RESP_SLVERR);
    bus(1'b1, ADDR_CTRL, 32'h40, RESP_OKAY);
    bus(1'b1, ADDR_CTRL, 32'h8, RESP_OKAY);
    wst(ST_NORMAL);
    bus(1'b1, ADDR_GATE, {24'h0, UNLOCK_KEY0}, RESP_OKAY);
    bus(1'b1, ADDR_GATE, {24'h0, UNLOCK_KEY1}, RESP_OKAY);
    bus(1'b1, ADDR_CTRL, 32'h20, RESP_OKAY);
    wst(ST_PROG);
    @(posedge clk) vldo_good <= 1'b0;
    wst(ST_POR);
    results();
  end
endmodule : led_mode_ctrl_tb_top
`default_nettype wire
